// [rtl/mbc_bus_master.sv]
`timescale 1ns/100ps
module mbc_bus_master
  import mbc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Core request side
  input  wire logic                  req_valid,
  input  mbc_pkg::mbc_req_s          req,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic [mbc_pkg::MBC_DATA_W-1:0] rsp_data,
  // Hold handshake
  input  wire logic                  hold_request,
  output logic                       bus_grant,
  // Bus pins
  output logic [7:0]                 upper_address,
  output logic [7:0]                 shared_addr_data_out,
  output logic                       shared_addr_data_oe,
  input  wire logic [7:0]            shared_addr_data_in,
  output logic                       addr_latch,
  output logic                       read_n,
  output logic                       write_n,
  output logic                       interrupt_ack_n,
  output logic                       io_space
);
  import mbc_pkg::*;

  // ==========================================================================
  // States
  typedef enum logic [3:0] {
    MBC_IDLE   = 4'b0001,
    MBC_LATCH  = 4'b0010,
    MBC_STROBE = 4'b0100,
    MBC_HOLD   = 4'b1000
  } mbc_state_e;

  // ==========================================================================
  // Cycle outline, the same for a read, a write and an acknowledge
  //   take edge   : full address and space select out, latch strobe high
  //   latch end   : latch strobe low, the strobe of the transfer kind falls,
  //                 and the shared lines turn to write data or are let go
  //   strobe end  : the strobe rises; read data is sampled on this very edge,
  //                 while the far device still drives the lines
  //   idle edge   : the shared lines are let go and parked at the idle value
  // Address and space select stay put from one take to the next, so neither
  // a far device nor an outside latch sees them move under a strobe.
  // A hold request is looked at only in idle and only while req_valid is low,
  // never inside a cycle. That costs up to one whole transfer of grant latency,
  // plus as long as req_valid stays high, but every strobe keeps its length
  // whether or not a grant is on the way.
  // Requests are taken in idle with hold_request low, whatever req_ready shows;
  // ready is a hint that matches the state but sees hold_request one edge late.

  mbc_state_e state_reg;
  mbc_state_e state_next;
  mbc_op_e    op_reg;
  logic [7:0] wdata_reg;
  logic       timer_load;
  logic [3:0] timer_len;
  logic       timer_done;

  // ==========================================================================
  // Phase timer shared by all strobe kinds, so their timing is identical
  mbc_phase_timer u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (timer_load),
    .length  (timer_len),
    .done    (timer_done)
  );

  // ==========================================================================
  // Level of an active-low strobe in the strobe phase: low only for the
  // transfer kind that it names
  function automatic logic strobe_level(input mbc_op_e cur, input mbc_op_e kind);
    return (cur != kind);
  endfunction : strobe_level

  // Decoding of state and transitions
  wire logic start_cyc   = (state_reg == MBC_IDLE) && req_valid && !hold_request;
  wire logic enter_hold  = (state_reg == MBC_IDLE) && !req_valid && hold_request;
  wire logic latch_end   = (state_reg == MBC_LATCH) && timer_done;
  wire logic strobe_end  = (state_reg == MBC_STROBE) && timer_done;
  wire logic is_write    = (op_reg == MBC_OP_WRITE);

  // Strobe levels for the strobe phase, all from one decode so that no kind
  // can drift away from the others
  wire logic read_level  = strobe_level(op_reg, MBC_OP_READ);
  wire logic write_level = strobe_level(op_reg, MBC_OP_WRITE);
  wire logic ack_level   = strobe_level(op_reg, MBC_OP_INTERRUPT_ACK_N);

  // Shared lines in the strobe phase: write data stays on through the rising
  // write edge, a read or an acknowledge lets them go for the far device
  wire logic [7:0] strobe_data = is_write ? wdata_reg : MBC_DATA_IDLE;
  wire logic       strobe_oe   = is_write;

  assign timer_load = start_cyc || latch_end;
  assign timer_len  = start_cyc ? MBC_LATCH_CYC : MBC_STROBE_CYC;

  // Next state; a grant is only entered between cycles so strobes never shorten
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      MBC_IDLE:
        if (start_cyc)
          state_next = MBC_LATCH;
        else if (enter_hold)
          state_next = MBC_HOLD;
      MBC_LATCH:
        if (latch_end)
          state_next = MBC_STROBE;
      MBC_STROBE:
        if (strobe_end)
          state_next = MBC_IDLE;
      MBC_HOLD:
        // Grant ends as soon as the request drops; the next cycle starts idle
        if (!hold_request)
          state_next = MBC_IDLE;
    endcase
  end

  // State and captured request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= MBC_IDLE;
      op_reg    <= MBC_OP_READ;
      wdata_reg <= MBC_DATA_IDLE;
    end
    else
    begin
      state_reg <= state_next;
      if (start_cyc)
      begin
        op_reg    <= req.op;
        wdata_reg <= req.wdata;
      end
    end
  end

  // ==========================================================================
  // Pin registers; every output comes from a flip-flop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Strobes idle high, lines let go, nothing granted
      upper_address        <= MBC_ADDR_IDLE[15:8];
      shared_addr_data_out <= MBC_DATA_IDLE;
      shared_addr_data_oe  <= 1'b0;
      addr_latch           <= 1'b0;
      read_n               <= 1'b1;
      write_n              <= 1'b1;
      interrupt_ack_n      <= 1'b1;
      io_space             <= 1'b0;
      bus_grant            <= 1'b0;
      req_ready            <= 1'b0;
      rsp_valid            <= 1'b0;
      rsp_data             <= MBC_DATA_IDLE;
    end
    else
    begin
      // Ready and grant look one state ahead, so each shows the state that
      // this edge enters rather than the one that it leaves
      req_ready <= (state_next == MBC_IDLE) && !hold_request;
      bus_grant <= (state_next == MBC_HOLD);
      rsp_valid <= 1'b0;
      if (start_cyc)
      begin
        // Full address out and latch pulse in the same phase
        upper_address        <= req.addr[15:8];
        shared_addr_data_out <= req.addr[7:0];
        shared_addr_data_oe  <= 1'b1;
        addr_latch           <= 1'b1;
        io_space             <= req.io_space;
      end
      else if (latch_end)
      begin
        addr_latch          <= 1'b0;
        // Reads release the lines; writes swap in data on the same edge that the latch falls
        read_n               <= read_level;
        interrupt_ack_n      <= ack_level;
        write_n              <= write_level;
        shared_addr_data_oe  <= strobe_oe;
        shared_addr_data_out <= strobe_data;
      end
      else if (strobe_end)
      begin
        // Data held through the rising write edge, captured there by devices
        read_n              <= 1'b1;
        write_n             <= 1'b1;
        interrupt_ack_n     <= 1'b1;
        rsp_valid           <= !is_write;
        // Device still drives until the read strobe rises, so sample now
        rsp_data            <= shared_addr_data_in;
      end
      else if (state_reg == MBC_IDLE)
      begin
        // Lines move on between cycles, ready for the next one
        shared_addr_data_oe  <= 1'b0;
        shared_addr_data_out <= MBC_DATA_IDLE;
      end
    end
  end

endmodule : mbc_bus_master

// [rtl/mbc_pkg.sv]
package mbc_pkg;

  // ==========================================================================
  // Bus widths
  localparam int MBC_ADDR_W = 16;
  localparam int MBC_DATA_W = 8;

  // ==========================================================================
  // Transfer kinds requested by the core
  typedef enum logic [1:0] {
    MBC_OP_READ  = 2'h0,
    MBC_OP_WRITE = 2'h1,
    MBC_OP_INTERRUPT_ACK_N  = 2'h2
  } mbc_op_e;

  // Request from the core side
  typedef struct packed {
    mbc_op_e                 op;
    logic                    io_space;
    logic [MBC_ADDR_W-1:0]   addr;
    logic [MBC_DATA_W-1:0]   wdata;
  } mbc_req_s;

  // ==========================================================================
  // Phase lengths in clock cycles
  localparam logic [3:0] MBC_LATCH_CYC  = 4'h1;
  localparam logic [3:0] MBC_STROBE_CYC = 4'h2;
  localparam logic [3:0] MBC_CNT_ZERO   = 4'h0;
  localparam logic [3:0] MBC_CNT_ONE    = 4'h1;

  // Idle values on the pins
  localparam logic [MBC_DATA_W-1:0] MBC_DATA_IDLE = 8'h00;
  localparam logic [MBC_ADDR_W-1:0] MBC_ADDR_IDLE = 16'h0000;

endpackage : mbc_pkg

// [rtl/mbc_phase_timer.sv]
`timescale 1ns/100ps
// Counts down one bus phase and pulses done on its last cycle
module mbc_phase_timer
  import mbc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       load,
  input  wire logic [3:0] length,
  output wire logic       done
);

  logic [3:0] count_reg;
  logic [3:0] count_next;

  // ==========================================================================
  // Next count; done is a pure decode of the count, since the load that it
  // triggers outside would otherwise loop straight back into it
  assign done       = (count_reg == MBC_CNT_ONE);
  assign count_next = load ? length
                    : (count_reg != MBC_CNT_ZERO) ? count_reg - MBC_CNT_ONE
                    : MBC_CNT_ZERO;

  // Counter register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_reg <= MBC_CNT_ZERO;
    else
      count_reg <= count_next;
  end

endmodule : mbc_phase_timer

// [sim/mbc_sva_checker_sva.sv]
`timescale 1ns/100ps
// ==========================================================================
// Bus cycle checker, sees only the master's ports
module mbc_sva_checker
  import mbc_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               reset_n,
  // Core side
  input mbc_pkg::mbc_req_s       req,
  input wire logic               rsp_valid,
  input wire logic               bus_grant,
  // Bus pins
  input wire logic [7:0]         upper_address,
  input wire logic [7:0]         shared_addr_data_out,
  input wire logic               shared_addr_data_oe,
  input wire logic               addr_latch,
  input wire logic               read_n,
  input wire logic               write_n,
  input wire logic               interrupt_ack_n,
  input wire logic               io_space
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A strobe is low for exactly two cycles, then idles high
  sequence two_low(s);
    !s ##1 !s ##1 s;
  endsequence
  // Kind of the taken request decides which strobe follows the latch
  property strobe_p(o, s);
    addr_latch && $past(req.op) == o |=> two_low(s);
  endproperty
  AST_LATCH_ADDR:
    assert property (addr_latch |-> shared_addr_data_oe && io_space == $past(req.io_space)
      && {upper_address, shared_addr_data_out} == $past(req.addr)) else $error("bad address");
  AST_LATCH_PULSE:
    assert property (addr_latch |=> !addr_latch) else $error("latch too long");
  AST_READ_STROBE:
    assert property (strobe_p(MBC_OP_READ, read_n)) else $error("read strobe timing");
  AST_WRITE_STROBE:
    assert property (strobe_p(MBC_OP_WRITE, write_n)) else $error("write strobe timing");
  AST_INTERRUPT_ACK_N_STROBE:
    assert property (strobe_p(MBC_OP_INTERRUPT_ACK_N, interrupt_ack_n)) else $error("ack strobe timing");
  AST_READ_RELEASE:
    assert property (!read_n || !interrupt_ack_n |-> !shared_addr_data_oe) else $error("bus held");
  AST_WRITE_DATA:
    assert property ($fell(write_n) |-> shared_addr_data_oe
      && shared_addr_data_out == $past(req.wdata, 2) ##1 $stable(shared_addr_data_out)
      ##1 write_n && shared_addr_data_oe && $stable(shared_addr_data_out))
      else $error("write data unstable");
  AST_SPACE_HOLD:
    assert property (!read_n || !write_n || !interrupt_ack_n |-> $stable(io_space)
      && $stable(upper_address)) else $error("space or address moved");
  AST_GRANT_IDLE:
    assert property (bus_grant |-> read_n && write_n && interrupt_ack_n && !addr_latch)
      else $error("strobe during grant");
  AST_READ_END:
    assert property ($rose(read_n) |-> rsp_valid ##1 !rsp_valid) else $error("no read answer");
endmodule : mbc_sva_checker

bind mbc_bus_master mbc_sva_checker u_chk (.*);

// [sim/mbc_far_dev.sv]
`timescale 1ns/100ps
// ==========================================================================
// Memory and port devices behind an external low-address latch
module mbc_far_dev
  import mbc_pkg::*;
#(
  parameter logic [7:0] ACK_VECTOR = 8'h5a // Arbitrary vector value
)
(
  // Clock
  input wire logic       clk,
  // Bus pins
  input wire logic [7:0] upper_address,
  input wire logic [7:0] bus,
  input wire logic       addr_latch,
  input wire logic       read_n,
  input wire logic       write_n,
  input wire logic       interrupt_ack_n,
  input wire logic       io_space,
  output logic [7:0]     dev_data,
  output logic           dev_oe
);
  logic [7:0] mem [65536];
  logic [7:0] port [256];
  logic [7:0] lo;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  // Separate space strobes decoded from read, write and space select
  wire memory_read_n  = read_n | io_space;
  wire memory_write_n = write_n | io_space;
  wire port_read_n    = read_n | !io_space;
  wire port_write_n   = write_n | !io_space;
  // Low byte captured while the latch strobe is high
  always @(posedge clk) if (addr_latch) lo <= bus;
  // Data taken on the trailing edge only, where it is guaranteed stable
  always @(posedge memory_write_n) mem[{upper_address, lo}] = bus;
  always @(posedge port_write_n) port[lo] = bus;
  // Drive only while the read or acknowledge strobe is low; released lines show the inverse
  assign val = !interrupt_ack_n ? ACK_VECTOR : io_space ? port[lo] : mem[{upper_address, lo}];
  assign dev_oe = !memory_read_n || !port_read_n || !interrupt_ack_n;
  assign dev_data = dev_oe ? val : ~last;
  always @(posedge clk) if (dev_oe) last <= val;
endmodule : mbc_far_dev

// [sim/muxed_cpu_system_bus_cycle_bench.sv]
`timescale 1ns/100ps
// ==========================================================================
// Bench for the multiplexed bus master
module muxed_cpu_system_bus_cycle_bench;
  import mbc_pkg::*;
  logic clk = 0, reset_n = 0, req_valid = 0, hold_request = 0, rdy, rv, bg, oe, al, rn, wn, an, io;
  logic [7:0] rd_data, ua, sdo, dev_data;
  logic dev_oe;
  mbc_req_s rq = '0;
  int err_count = 0, n_tests = 0;
  // Wire level: master wins while it drives, else the far side
  wire [7:0] bus = oe ? sdo : dev_data;
  initial forever #10 clk = ~clk;
  mbc_bus_master DUT (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(rq),
    .req_ready(rdy), .rsp_valid(rv), .rsp_data(rd_data), .hold_request(hold_request),
    .bus_grant(bg), .upper_address(ua), .shared_addr_data_out(sdo), .shared_addr_data_oe(oe),
    .shared_addr_data_in(bus), .addr_latch(al), .read_n(rn), .write_n(wn),
    .interrupt_ack_n(an), .io_space(io));
  mbc_far_dev #(.ACK_VECTOR(8'h5a)) u_dev (.clk(clk), .upper_address(ua), .bus(bus),
    .addr_latch(al), .read_n(rn), .write_n(wn), .interrupt_ack_n(an), .io_space(io),
    .dev_data(dev_data), .dev_oe(dev_oe));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // One whole bus cycle; request held until the latch shows it was taken
  task xfer(input mbc_op_e op, input logic s, input logic [15:0] a, input logic [7:0] d,
            output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    rq <= '{op, s, a, d};
    do begin @(posedge clk); #1; n++; end while (al !== 1'b1 && n < 20);
    if (al !== 1'b1) begin err_count++; report_and_stop(); end
    chk({ua, sdo}, a);
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    if (op == MBC_OP_WRITE) chk({oe, sdo}, {1'b1, d});
    else chk(oe, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    r = rd_data;
    chk({rv, rdy}, {op != MBC_OP_WRITE, !hold_request});
  endtask : xfer
  // Both spaces at the same low byte, top address, back to back
  task sc_spaces;
    logic [7:0] r;
    xfer(MBC_OP_WRITE, 0, 16'h12a5, 8'h3c, r);
    xfer(MBC_OP_WRITE, 1, 16'h00a5, 8'hc3, r);
    xfer(MBC_OP_WRITE, 0, 16'hffff, 8'h81, r);
    xfer(MBC_OP_READ, 0, 16'h12a5, 8'h00, r);
    chk(r, 8'h3c);
    xfer(MBC_OP_READ, 1, 16'h00a5, 8'h00, r);
    chk(r, 8'hc3);
    xfer(MBC_OP_READ, 0, 16'hffff, 8'h00, r);
    chk(r, 8'h81);
    xfer(MBC_OP_INTERRUPT_ACK_N, 0, 16'h0000, 8'h00, r);
    chk(r, 8'h5a);
  endtask : sc_spaces
  // Grant asked for in mid-read: strobes keep their timing, grant waits for idle
  task sc_hold;
    int n;
    logic [7:0] r;
    fork
      xfer(MBC_OP_READ, 0, 16'h12a5, 8'h00, r);
      begin @(posedge al); @(posedge clk) hold_request <= 1'b1; end
    join
    chk(r, 8'h3c);
    for (n = 0; n < 10 && bg !== 1'b1; n++) @(posedge clk);
    if (bg !== 1'b1) begin err_count++; report_and_stop(); end
    #1;
    chk({bg, rdy, rn, wn, an, al}, 6'h2e);
    @(posedge clk) hold_request <= 1'b0;
    xfer(MBC_OP_READ, 0, 16'h12a5, 8'h00, r);
    chk({bg, r}, {1'b0, 8'h3c});
  endtask : sc_hold
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    sc_spaces();
    sc_hold();
    report_and_stop();
  end
endmodule : muxed_cpu_system_bus_cycle_bench
